// ===== common/pedc_pkg.sv
package pedc_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] PEDC_OFF_ADDR_UPPER = 12'h270;
	localparam logic [11:0] PEDC_OFF_ADDR_LOWER = 12'h274;
	localparam logic [11:0] PEDC_OFF_ATTR_WORD = 12'h278;
	localparam logic [11:0] PEDC_OFF_SPLIT_MSG = 12'h27C;
	localparam logic [11:0] PEDC_OFF_ERR_ATTR = 12'h280;

	// ------------------------------------------------------------
	// Attributes register field positions
	// ------------------------------------------------------------
	localparam int PEDC_BIT_STATUS = 31;
	localparam int PEDC_BIT_OVERFLOW = 30;
	localparam int PEDC_BIT_CLEAR = 29;
	localparam int PEDC_BIT_SCD = 17;
	localparam int PEDC_BIT_USC = 16;
	localparam int PEDC_BIT_SRT = 15;
	localparam int PEDC_BIT_SPLIT_COMPLETION_ERROR_MESSAGE = 14;
	localparam int PEDC_BIT_MDP = 13;
	localparam int PEDC_BIT_DPE = 12;
	localparam int PEDC_BIT_RETRY = 11;
	localparam int PEDC_BIT_RMA = 10;
	localparam int PEDC_BIT_RTA = 9;
	localparam int PEDC_BIT_DTT = 8;
	localparam int PEDC_CBE_LSB = 4;
	localparam int PEDC_CMD_LSB = 0;
	localparam int PEDC_NUM_CAUSES = 10;

	// ------------------------------------------------------------
	// Reset values and AXI responses
	// ------------------------------------------------------------
	localparam logic [31:0] PEDC_RST_WORD = 32'h0000_0000;
	localparam logic [PEDC_NUM_CAUSES-1:0] PEDC_RST_CAUSE = 10'h000;
	localparam logic [3:0] PEDC_RST_NIB = 4'h0;
	localparam logic [1:0] PEDC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PEDC_RESP_SLVERR = 2'h2;

	// Cause vector index: bit i maps to attributes bit PEDC_BIT_DTT + i
	localparam int PEDC_CAUSE_BASE = PEDC_BIT_DTT;

endpackage

// ===== design/pedc_capture.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// R1: Latch split completion message on error
// R2: Capture updates only while status flag clear or in the cycle a clear lands
// R3: Set status flag on every new capture
// R4: Writing clear bit one clears status
// R5: Error while frozen, outside the clear cycle, sets overflow only
// R6: Writing clear bit one clears overflow
// R7: Clear zeroes address upper, lower, attributes
// R8: Clear bit reads zero; zero ignored
// R9: Bit 17 split completion discarded
// R10: Bit 16 unexpected split completion
// R11: Bit 15 split response timeout
// R12: Bit 14 split completion error message
// R13: Bit 13 needs parity_error_response_enable, master, enable
// R14: Bit 12 master read or target write parity
// R15: Bit 11 retry limit exceeded
// R16: Bit 10 received master abort
// R17: Bit 9 received target abort
// R18: Bit 8 delayed transaction timeout
// R19: Bits 7:4 attribute phase byte enables
// R20: Bits 3:0 bus command
// R21: Everything resets to zero
// R22: Latch address upper on error
// R23: Latch address lower on error
// R24: Latch attribute phase AD word
// R25: Whole capture loads in one cycle
// R26: Bits 28:18 read zero, ignore writes
module pedc_capture
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic err_event,
	input wire logic [63:0] err_address,
	input wire logic [31:0] err_attr_word,
	input wire logic [31:0] err_split_msg,
	input wire logic [3:0] err_byte_enable_attr,
	input wire logic [3:0] err_bus_command,
	input wire logic cause_split_completion_discarded,
	input wire logic cause_unexpected_split_completion,
	input wire logic cause_split_response_timeout,
	input wire logic cause_split_completion_error_message,
	input wire logic cause_parity_error_response_enable_seen,
	input wire logic cause_was_bus_master,
	input wire logic parity_error_response_enable,
	input wire logic cause_master_read_parity,
	input wire logic cause_target_write_parity,
	input wire logic cause_retry_limit,
	input wire logic cause_received_master_abort,
	input wire logic cause_received_target_abort,
	input wire logic cause_delayed_transaction_timeout,
	output logic diag_status_flag,
	output logic diag_overflow_flag
);
	import pedc_pkg::*;

	// ------------------------------------------------------------
	// Capture storage
	// ------------------------------------------------------------
	logic [31:0] captured_address_upper_r;
	logic [31:0] captured_address_lower_r;
	logic [31:0] captured_attribute_word_r;
	logic [31:0] split_msg_capture_r;
	logic [PEDC_NUM_CAUSES-1:0] cause_r;
	logic [PEDC_NUM_CAUSES-1:0] cause_nxt;
	logic [3:0] byte_enable_attribute_r;
	logic [3:0] bus_command_capture_r;
	logic diag_status_flag_r;
	logic diag_overflow_flag_r;
	logic clear_hit;
	logic [31:0] attr_read;

	// Decode and qualification helpers
	logic capture_load;
	logic mdp_qualified;
	logic dpe_any;
	logic [11:0] wr_word_addr;
	logic wr_addr_ok;
	logic [31:0] rd_word;
	logic rd_ok;

	// ------------------------------------------------------------
	// AXI write channel state
	// ------------------------------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic wr_fire;

	// Either channel may come first; each is parked until both are in
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			awaddr_r <= 12'h000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_held_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_r <= 1'b0;
			wdata_r <= PEDC_RST_WORD;
			wstrb_r <= PEDC_RST_NIB;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_held_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	// Low address bits are dropped; every register is one aligned word
	assign wr_word_addr = {awaddr_r[11:2], 2'b00};

	// Captures are read-only; all five registers answer a write with OKAY, but only the attributes register acts on it
	always_comb
	begin
		wr_addr_ok = 1'b0;
		unique case (wr_word_addr)
			PEDC_OFF_ADDR_UPPER, PEDC_OFF_ADDR_LOWER, PEDC_OFF_ATTR_WORD,
			PEDC_OFF_SPLIT_MSG, PEDC_OFF_ERR_ATTR: wr_addr_ok = 1'b1;
			default: wr_addr_ok = 1'b0;
		endcase
	end

	// Response is held until the master takes it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bvalid_r <= 1'b0;
		else if (wr_fire)
			bvalid_r <= 1'b1;
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bresp_r <= PEDC_RESP_OKAY;
		else if (wr_fire)
			bresp_r <= wr_addr_ok ? PEDC_RESP_OKAY : PEDC_RESP_SLVERR;
	end

	// Clear acts only on a one in the top byte lane
	assign clear_hit = wr_fire && (wr_word_addr == PEDC_OFF_ERR_ATTR)
		&& wstrb_r[3] && wdata_r[PEDC_BIT_CLEAR]; // R4 R6 R8

	// ------------------------------------------------------------
	// Cause qualification
	// ------------------------------------------------------------
	// Master parity flag needs all three qualifiers at once
	assign mdp_qualified = cause_parity_error_response_enable_seen && cause_was_bus_master
		&& parity_error_response_enable; // R13
	assign dpe_any = cause_master_read_parity || cause_target_write_parity; // R14

	always_comb
	begin
		cause_nxt = PEDC_RST_CAUSE;
		cause_nxt[PEDC_BIT_SCD - PEDC_CAUSE_BASE] = cause_split_completion_discarded; // R9
		cause_nxt[PEDC_BIT_USC - PEDC_CAUSE_BASE] = cause_unexpected_split_completion; // R10
		cause_nxt[PEDC_BIT_SRT - PEDC_CAUSE_BASE] = cause_split_response_timeout; // R11
		cause_nxt[PEDC_BIT_SPLIT_COMPLETION_ERROR_MESSAGE - PEDC_CAUSE_BASE] = cause_split_completion_error_message; // R12
		cause_nxt[PEDC_BIT_MDP - PEDC_CAUSE_BASE] = mdp_qualified; // R13
		cause_nxt[PEDC_BIT_DPE - PEDC_CAUSE_BASE] = dpe_any; // R14
		cause_nxt[PEDC_BIT_RETRY - PEDC_CAUSE_BASE] = cause_retry_limit; // R15
		cause_nxt[PEDC_BIT_RMA - PEDC_CAUSE_BASE] = cause_received_master_abort; // R16
		cause_nxt[PEDC_BIT_RTA - PEDC_CAUSE_BASE] = cause_received_target_abort; // R17
		cause_nxt[PEDC_BIT_DTT - PEDC_CAUSE_BASE] = cause_delayed_transaction_timeout; // R18
	end

	// ------------------------------------------------------------
	// Capture and freeze
	// ------------------------------------------------------------
	// An error in the clear cycle is kept: the set wins, so no event is lost,
	// and the new capture lands whole in the freshly cleared set.
	assign capture_load = err_event && (!diag_status_flag_r || clear_hit); // R2 R25

	// Address halves
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			captured_address_upper_r <= PEDC_RST_WORD; // R21
			captured_address_lower_r <= PEDC_RST_WORD; // R21
		end
		else if (capture_load)
		begin
			captured_address_upper_r <= err_address[63:32]; // R22
			captured_address_lower_r <= err_address[31:0]; // R23
		end
		else if (clear_hit)
		begin
			captured_address_upper_r <= PEDC_RST_WORD; // R7
			captured_address_lower_r <= PEDC_RST_WORD; // R7
		end
	end

	// Attribute phase word is not touched by a clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			captured_attribute_word_r <= PEDC_RST_WORD; // R21
		else if (capture_load)
			captured_attribute_word_r <= err_attr_word; // R24
	end

	// Split message is not touched by a clear either
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			split_msg_capture_r <= PEDC_RST_WORD; // R21
		else if (capture_load)
			split_msg_capture_r <= err_split_msg; // R1
	end

	// Cause flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cause_r <= PEDC_RST_CAUSE; // R21
		else if (capture_load)
			cause_r <= cause_nxt; // R25
		else if (clear_hit)
			cause_r <= PEDC_RST_CAUSE; // R7
	end

	// Byte enables and command
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			byte_enable_attribute_r <= PEDC_RST_NIB; // R21
			bus_command_capture_r <= PEDC_RST_NIB; // R21
		end
		else if (capture_load)
		begin
			byte_enable_attribute_r <= err_byte_enable_attr; // R19
			bus_command_capture_r <= err_bus_command; // R20
		end
		else if (clear_hit)
		begin
			byte_enable_attribute_r <= PEDC_RST_NIB; // R7
			bus_command_capture_r <= PEDC_RST_NIB; // R7
		end
	end

	// Status flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			diag_status_flag_r <= 1'b0; // R21
		else if (capture_load)
			diag_status_flag_r <= 1'b1; // R3
		else if (clear_hit)
			diag_status_flag_r <= 1'b0; // R4
	end

	// Overflow only counts errors that arrive while frozen
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			diag_overflow_flag_r <= 1'b0; // R21
		else if (clear_hit)
			diag_overflow_flag_r <= 1'b0; // R6
		else if (err_event && diag_status_flag_r)
			diag_overflow_flag_r <= 1'b1; // R5
	end

	// ------------------------------------------------------------
	// Flag outputs
	// ------------------------------------------------------------
	assign diag_status_flag = diag_status_flag_r;
	assign diag_overflow_flag = diag_overflow_flag_r;

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	always_comb
	begin
		attr_read = PEDC_RST_WORD; // R26
		attr_read[PEDC_BIT_STATUS] = diag_status_flag_r;
		attr_read[PEDC_BIT_OVERFLOW] = diag_overflow_flag_r;
		attr_read[PEDC_BIT_CLEAR] = 1'b0; // R8
		attr_read[PEDC_BIT_SCD:PEDC_BIT_DTT] = cause_r;
		attr_read[PEDC_CBE_LSB +: 4] = byte_enable_attribute_r;
		attr_read[PEDC_CMD_LSB +: 4] = bus_command_capture_r;
	end

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	// Unmapped reads return zero with an error response
	always_comb
	begin
		rd_word = PEDC_RST_WORD;
		rd_ok = 1'b1;
		unique case ({s_axi_araddr[11:2], 2'b00})
			PEDC_OFF_ADDR_UPPER: rd_word = captured_address_upper_r;
			PEDC_OFF_ADDR_LOWER: rd_word = captured_address_lower_r;
			PEDC_OFF_ATTR_WORD: rd_word = captured_attribute_word_r;
			PEDC_OFF_SPLIT_MSG: rd_word = split_msg_capture_r;
			PEDC_OFF_ERR_ATTR: rd_word = attr_read;
			default: rd_ok = 1'b0;
		endcase
	end

	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// One read at a time: the address waits while data is pending
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= PEDC_RST_WORD;
			rresp_r <= PEDC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_ok ? PEDC_RESP_OKAY : PEDC_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

endmodule

// ===== verification/pedc_bus_model.sv
`timescale 1ns/1ps
module pedc_bus_model
(
	input wire logic aclk,
	input wire logic go,
	input wire logic [31:0] pat,
	input wire logic [12:0] cs,
	output logic err_event = 1'b0,
	output logic [63:0] err_address = '0,
	output logic [31:0] err_attr_word = '0,
	output logic [31:0] err_split_msg = '0,
	output logic [7:0] err_attr_nib = '0,
	output logic [12:0] cause = '0
);
	// Idle lines flip each cycle so a stale payload never passes
	always_ff @(posedge aclk)
	begin
		err_event <= go;
		err_address <= go ? {pat, ~pat} : ~err_address;
		err_attr_word <= go ? pat ^ 32'hFFFF_0000 : ~err_attr_word;
		err_split_msg <= go ? pat ^ 32'h0000_FFFF : ~err_split_msg;
		err_attr_nib <= go ? pat[7:0] : ~err_attr_nib;
		cause <= go ? cs : ~cause;
	end
endmodule

// ===== verification/pedc_capture_sva.sv
`timescale 1ns/1ps
module pedc_capture_chk
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic err_event,
	input wire logic diag_status_flag,
	input wire logic diag_overflow_flag
);
	import pedc_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Nothing held on the write side, so no clear lands next edge
	sequence bus_idle;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence error_frozen;
		err_event && diag_status_flag ##0 bus_idle;
	endsequence
	status_set_a: assert property (err_event && !diag_status_flag ##0 bus_idle |=> diag_status_flag)
		else $error("status not set by error");
	overflow_set_a: assert property (error_frozen |=> diag_overflow_flag && diag_status_flag)
		else $error("overflow not set");
	status_cause_a: assert property ($rose(diag_status_flag) |-> $past(err_event))
		else $error("status rose without error");
	overflow_cause_a: assert property ($rose(diag_overflow_flag) |-> $past(diag_status_flag))
		else $error("overflow rose while not frozen");
	status_hold_a: assert property (diag_status_flag ##0 bus_idle |=> diag_status_flag)
		else $error("status dropped without clear");
	clear_both_a: assert property ($fell(diag_status_flag) |-> $rose(s_axi_bvalid) && !diag_overflow_flag)
		else $error("flags not cleared by a write");
	overflow_only_a: assert property (diag_overflow_flag |-> diag_status_flag)
		else $error("overflow without status");
	unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == PEDC_RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("error read not zero");
endmodule

bind pedc_capture pedc_capture_chk i_pedc_capture_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .err_event, .diag_status_flag,
	.diag_overflow_flag);

// ===== verification/pedc_capture_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module pedc_capture_tb;
	import pedc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0;
	logic [11:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, go = 1'b0;
	logic [31:0] pat = '0;
	logic [12:0] cs = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, err_attr_word, err_split_msg;
	logic err_event, diag_status_flag, diag_overflow_flag;
	logic [63:0] err_address;
	logic [7:0] err_attr_nib;
	logic [12:0] cause;
	logic [1:0] r;
	int err_total = 0;
	int checked = 0;

	always #2.5 aclk = ~aclk;

	pedc_bus_model i_pedc_bus_model (.aclk, .go, .pat, .cs, .err_event, .err_address,
		.err_attr_word, .err_split_msg, .err_attr_nib, .cause);
	pedc_capture i_pedc_capture (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .err_event, .err_address, .err_attr_word, .err_split_msg,
		.err_byte_enable_attr(err_attr_nib[7:4]), .err_bus_command(err_attr_nib[3:0]),
		.cause_split_completion_discarded(cause[0]), .cause_unexpected_split_completion(cause[1]),
		.cause_split_response_timeout(cause[2]), .cause_split_completion_error_message(cause[3]),
		.cause_parity_error_response_enable_seen(cause[4]), .cause_was_bus_master(cause[5]),
		.parity_error_response_enable(cause[6]), .cause_master_read_parity(cause[7]),
		.cause_target_write_parity(cause[8]), .cause_retry_limit(cause[9]),
		.cause_received_master_abort(cause[10]), .cause_received_target_abort(cause[11]),
		.cause_delayed_transaction_timeout(cause[12]), .diag_status_flag, .diag_overflow_flag);

	function automatic logic [31:0] ex(input logic [12:0] c, input logic [31:0] p);
		return {2'h2, 12'h000, c[0], c[1], c[2], c[3], &c[6:4], |c[8:7], c[9], c[10], c[11], c[12],
			p[7:0]};
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd))
		begin
			@(negedge aclk);
			ad = ad | s_axi_awready;
			wd = wd | s_axi_wready;
			@(posedge aclk);
			if (ad) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, er)
		@(posedge aclk);
	endtask

	// Capture lands at the edge that samples the pulse
	task automatic fire(input logic [31:0] p, input logic [12:0] c);
		go <= 1'b1;
		pat <= p;
		cs <= c;
		@(posedge aclk);
		go <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic t_reset;
		for (int i = 0; i < 5; i++) rd(12'h270 + 12'(i * 4), '0, PEDC_RESP_OKAY);
		rd(12'h284, '0, PEDC_RESP_SLVERR);
		wr(12'h2A0, '1, r);
		`CHK(r, PEDC_RESP_SLVERR)
	endtask

	task automatic t_freeze;
		fire(32'hCAFE_0123, 13'h0400);
		rd(PEDC_OFF_ADDR_UPPER, 32'hCAFE_0123, PEDC_RESP_OKAY);
		rd(PEDC_OFF_ADDR_LOWER, 32'h3501_FEDC, PEDC_RESP_OKAY);
		rd(PEDC_OFF_ATTR_WORD, 32'h3501_0123, PEDC_RESP_OKAY);
		rd(PEDC_OFF_SPLIT_MSG, 32'hCAFE_FEDC, PEDC_RESP_OKAY);
		fire(32'h0BAD_F00D, 13'h0001);
		@(negedge aclk);
		`CHK(diag_overflow_flag, 1'b1)
		wr(PEDC_OFF_ADDR_LOWER, '1, r);
		`CHK(r, PEDC_RESP_OKAY)
		rd(PEDC_OFF_ADDR_LOWER, 32'h3501_FEDC, PEDC_RESP_OKAY);
		wr(PEDC_OFF_ERR_ATTR, 32'hDFFF_FFFF, r);
		rd(PEDC_OFF_ERR_ATTR, ex(13'h0400, 32'h23) | 32'h4000_0000, PEDC_RESP_OKAY);
		s_axi_wstrb <= 4'h7;
		wr(PEDC_OFF_ERR_ATTR, 32'h2000_0000, r);
		s_axi_wstrb <= 4'hF;
		`CHK(diag_status_flag, 1'b1)
		wr(PEDC_OFF_ERR_ATTR, 32'h2000_0000, r);
		`CHK(diag_status_flag, 1'b0)
		rd(PEDC_OFF_ERR_ATTR, '0, PEDC_RESP_OKAY);
		rd(PEDC_OFF_ADDR_UPPER, '0, PEDC_RESP_OKAY);
		rd(PEDC_OFF_ADDR_LOWER, '0, PEDC_RESP_OKAY);
		rd(PEDC_OFF_ATTR_WORD, 32'h3501_0123, PEDC_RESP_OKAY);
		rd(PEDC_OFF_SPLIT_MSG, 32'hCAFE_FEDC, PEDC_RESP_OKAY);
	endtask

	// Error in the very cycle the clear lands: the set wins
	task automatic t_collide;
		fire(32'h2468_ACE1, 13'h0800);
		fire(32'h1111_2222, 13'h0002);
		fork
			fire(32'h5A5A_3C3C, 13'h1000);
			wr(PEDC_OFF_ERR_ATTR, 32'h2000_0000, r);
		join
		@(negedge aclk);
		`CHK(diag_overflow_flag, 1'b0)
		rd(PEDC_OFF_ERR_ATTR, ex(13'h1000, 32'h3C), PEDC_RESP_OKAY);
		rd(PEDC_OFF_ADDR_UPPER, 32'h5A5A_3C3C, PEDC_RESP_OKAY);
		rd(PEDC_OFF_SPLIT_MSG, 32'h5A5A_C3C3, PEDC_RESP_OKAY);
		wr(PEDC_OFF_ERR_ATTR, 32'h2000_0000, r);
	endtask

	task automatic t_causes;
		logic [12:0] c;
		logic [31:0] p;
		for (int i = 0; i < 15; i++)
		begin
			c = i < 13 ? 13'h0001 << i : (i == 13 ? 13'h0070 : 13'h1FFF);
			p = 32'h1357_9BD0 + 32'(i * 37);
			fire(p, c);
			rd(PEDC_OFF_ERR_ATTR, ex(c, p), PEDC_RESP_OKAY);
			wr(PEDC_OFF_ERR_ATTR, 32'h2000_0000, r);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_freeze;
		t_causes;
		t_collide;
		test_done;
	end

	// About a hundred times the expected run
	initial
	begin
		repeat (20000) @(posedge aclk);
		err_total++;
		test_done;
	end
endmodule
